// ===== uec_pkg.sv
package uec_pkg;
    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int UEC_WORD_W = 41;
    localparam int UEC_QP_LSB = 0;
    localparam int UEC_QP_W = 6;
    localparam int UEC_NUM_PRED = 64;
    localparam int UEC_SLOT_W = 2;
    localparam logic [1:0] UEC_TAIL_SLOT = 2'h2;
    localparam logic [5:0] UEC_QP_RESET = 6'h00;

    typedef enum logic [1:0] {
        UEC_CLS_VALID,
        UEC_CLS_IGNORED,
        UEC_CLS_RESERVED,
        UEC_CLS_RSV_PRED
    } uec_class_e;

    typedef enum logic [1:0] {
        UEC_ACT_EXEC,
        UEC_ACT_NOP,
        UEC_ACT_FAULT
    } uec_action_e;

    // Fetched word plus the table lookup made upstream
    typedef struct packed {
        logic [40:0] word;
        uec_class_e cls;
        logic [40:0] zero_mask;
        logic zero_has_qp;
        logic [1:0] slot;
        logic first_mark;
        logic last_mark;
        logic tail_mark;
    } uec_inst_s;

    typedef struct packed {
        uec_class_e cls;
        uec_action_e action;
        logic illegal_op;
        logic placement_err;
        logic [5:0] pred_sel;
    } uec_result_s;
endpackage : uec_pkg

// ===== uec_pred_select.sv
`timescale 1ns/1ps
`default_nettype none
module uec_pred_select #(
    parameter int NUM_PRED = 64
) (
    input wire logic [NUM_PRED-1:0] predicate_register_file,
    input wire logic [$clog2(NUM_PRED)-1:0] qualifying_predicate_field,
    output logic selected_predicate_bit
);
    initial begin
        if (NUM_PRED < 2) begin
            $error("NUM_PRED too small");
        end
    end
    // Entry zero is hardwired true in the predicate file
    always_comb begin
        if (qualifying_predicate_field == '0) begin
            selected_predicate_bit = 1'b1;
        end else begin
            selected_predicate_bit =
                predicate_register_file[qualifying_predicate_field];
        end
    end
endmodule : uec_pred_select
`default_nettype wire

// ===== uec_classifier.sv
// Notes on behaviour
// (RULE_01) Ignored encodings retire as no-operations
// (RULE_02) Reserved encodings raise illegal-operation fault
// (RULE_03) Predicated-reserved: fault if predicate one, else nop
// (RULE_04) Nonzero constant-zero field may fault
// (RULE_05) Predicate zero suppresses constant-zero fault
// (RULE_06) Zero field in bits 5:0 ignores predicate
// (RULE_07) Software codes ignored fields as zero
// (RULE_08) Ignored field contents never change behaviour
// (RULE_09) First-in-group marked instruction placed first
// (RULE_10) Last-in-group marked instruction placed last
// (RULE_11) Slot-restricted instruction only in slot 2
// (RULE_12) Output class and execute/nop/fault action
`timescale 1ns/1ps
`default_nettype none
module uec_classifier
    import uec_pkg::*;
#(
    parameter int NUM_PRED = uec_pkg::UEC_NUM_PRED,
    parameter bit CHECK_ZERO = 1'b1,
    parameter bit CHECK_PLACE = 1'b1
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic in_valid,
    input wire uec_pkg::uec_inst_s in_inst,
    input wire logic group_start,
    input wire logic group_end,
    input wire logic [NUM_PRED-1:0] predicate_register_file,
    output logic out_valid,
    output uec_pkg::uec_result_s out_res
);
    import uec_pkg::*;

    initial begin
        if (NUM_PRED != 64) begin
            $error("Predicate field is six bits, NUM_PRED must be 64");
        end
    end

    // ------------------------------------------------------------
    // Predicate lookup
    // ------------------------------------------------------------
    logic [UEC_QP_W-1:0] qualifying_predicate_field;
    logic selected_predicate_bit;

    assign qualifying_predicate_field =
        in_inst.word[UEC_QP_LSB +: UEC_QP_W];

    uec_pred_select #(
        .NUM_PRED(NUM_PRED)
    ) u_pred (
        .predicate_register_file(predicate_register_file),
        .qualifying_predicate_field(qualifying_predicate_field),
        .selected_predicate_bit(selected_predicate_bit)
    );

    // ------------------------------------------------------------
    // Classification
    // ------------------------------------------------------------
    logic zero_bad;
    logic zero_fault;
    logic place_bad;
    logic next_out_valid;
    uec_result_s next_out_res;

    // Only masked bits are examined; all others are don't-care
    assign zero_bad = |(in_inst.word & in_inst.zero_mask); // RULE_08

    always_comb begin
        // Predicate gating only where bits 5:0 are a real predicate
        if (!CHECK_ZERO || !zero_bad) begin
            zero_fault = 1'b0;
        end else if (in_inst.zero_has_qp) begin
            zero_fault = selected_predicate_bit; // RULE_05
        end else begin
            zero_fault = 1'b1; // RULE_04 RULE_06
        end
    end

    // Placement misuse is reported, not enforced as a fault
    always_comb begin
        place_bad = 1'b0;
        if (CHECK_PLACE) begin
            place_bad = (in_inst.first_mark && !group_start) // RULE_09
                || (in_inst.last_mark && !group_end) // RULE_10
                || (in_inst.tail_mark
                    && in_inst.slot != UEC_TAIL_SLOT); // RULE_11
        end
    end

    always_comb begin
        next_out_valid = in_valid;
        next_out_res.cls = in_inst.cls; // RULE_12
        next_out_res.pred_sel = qualifying_predicate_field;
        next_out_res.placement_err = in_valid && place_bad;
        next_out_res.action = UEC_ACT_EXEC;
        unique case (in_inst.cls)
            UEC_CLS_VALID: begin
                if (zero_fault) begin
                    next_out_res.action = UEC_ACT_FAULT;
                end else if (in_inst.zero_has_qp
                    && !selected_predicate_bit) begin
                    next_out_res.action = UEC_ACT_NOP;
                end
            end
            UEC_CLS_IGNORED: begin
                next_out_res.action = UEC_ACT_NOP; // RULE_01
            end
            UEC_CLS_RESERVED: begin
                next_out_res.action = UEC_ACT_FAULT; // RULE_02
            end
            UEC_CLS_RSV_PRED: begin
                next_out_res.action = selected_predicate_bit ?
                    UEC_ACT_FAULT : UEC_ACT_NOP; // RULE_03
            end
        endcase
        next_out_res.illegal_op = in_valid
            && (next_out_res.action == UEC_ACT_FAULT);
    end

    // ------------------------------------------------------------
    // Output register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            out_valid <= 1'b0;
            out_res <= '{cls: UEC_CLS_VALID, action: UEC_ACT_EXEC,
                illegal_op: 1'b0, placement_err: 1'b0,
                pred_sel: UEC_QP_RESET};
        end else if (ce) begin
            out_valid <= next_out_valid;
            out_res <= next_out_res;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_IGNORED_NOP: assert property (@(posedge clk) disable iff (srst) // RULE_01
        ce && in_valid && in_inst.cls == UEC_CLS_IGNORED
        |=> out_res.action == UEC_ACT_NOP && !out_res.illegal_op)
        else $error("ignored encoding not a nop");

    AST_RESERVED_FAULT: assert property (@(posedge clk) disable iff (srst) // RULE_02
        ce && in_valid && in_inst.cls == UEC_CLS_RESERVED
        |=> out_res.illegal_op && out_valid)
        else $error("reserved encoding did not fault");

    AST_RSV_PRED: assert property (@(posedge clk) disable iff (srst) // RULE_03
        ce && in_valid && in_inst.cls == UEC_CLS_RSV_PRED
        |=> out_res.illegal_op == $past(selected_predicate_bit))
        else $error("predicated reserved outcome wrong");

    AST_ZERO_NOQP: assert property (@(posedge clk) disable iff (srst) // RULE_06
        ce && in_valid && in_inst.cls == UEC_CLS_VALID && CHECK_ZERO
        && zero_bad && !in_inst.zero_has_qp |=> out_res.illegal_op)
        else $error("nonzero constant field not faulted");

    AST_ZERO_SUPPRESS: assert property (@(posedge clk) disable iff (srst) // RULE_05
        ce && in_valid && in_inst.cls == UEC_CLS_VALID
        && in_inst.zero_has_qp && !selected_predicate_bit
        |=> !out_res.illegal_op)
        else $error("fault with false predicate");

    AST_ZERO_FAULT: assert property (@(posedge clk) disable iff (srst) // RULE_04
        ce && in_valid && in_inst.cls == UEC_CLS_VALID && CHECK_ZERO
        && zero_bad && selected_predicate_bit |=> out_res.illegal_op)
        else $error("constant field fault missing");

    AST_IGNORED_FIELDS: assert property (@(posedge clk) disable iff (srst) // RULE_08
        ce && in_valid && in_inst.cls == UEC_CLS_VALID && !zero_bad
        && selected_predicate_bit |=> out_res.action == UEC_ACT_EXEC)
        else $error("ignored field changed behaviour");

    AST_SLOT: assert property (@(posedge clk) disable iff (srst) // RULE_11
        ce && in_valid && CHECK_PLACE && in_inst.tail_mark
        && in_inst.slot != UEC_TAIL_SLOT |=> out_res.placement_err)
        else $error("slot restriction not reported");

    AST_CLASS: assert property (@(posedge clk) disable iff (srst) // RULE_12
        ce |=> out_res.cls == $past(in_inst.cls)
        && out_valid == $past(in_valid))
        else $error("class not passed through");

    AST_FREEZE: assert property (@(posedge clk) disable iff (srst)
        !ce |=> $stable(out_res) && $stable(out_valid))
        else $error("state moved with enable low");
endmodule : uec_classifier
`default_nettype wire

// ===== uec_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
module uec_fetch_model
    import uec_pkg::*;
(
    input wire logic clk,
    input wire logic send,
    input wire uec_pkg::uec_inst_s req,
    input wire logic [40:0] noise,
    input wire logic bad,
    output logic in_valid,
    output uec_pkg::uec_inst_s in_inst,
    output logic group_start,
    output logic group_end
);
    uec_inst_s fetch_word;
    initial begin
        in_valid = 1'b0;
        in_inst = '0;
        group_start = 1'b0;
        group_end = 1'b0;
    end
    // ----------------------------------------
    // Fetch side
    // ----------------------------------------
    // Idle cycles scramble the bus so stale words never look usable
    always @(negedge clk) begin
        fetch_word = req;
        fetch_word.word = req.word | noise;
        if (req.tail_mark) begin
            fetch_word.slot = bad ? 2'h1 : UEC_TAIL_SLOT;
        end
        in_valid <= send;
        if (send) begin
            in_inst <= fetch_word;
            group_start <= req.first_mark ^ bad;
            group_end <= req.last_mark ^ bad;
        end else begin
            in_inst <= ~in_inst;
            group_start <= ~group_start;
            group_end <= ~group_end;
        end
    end
endmodule : uec_fetch_model
`default_nettype wire

// ===== uec_classifier_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module uec_classifier_tb_top;
    import uec_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic send = 1'b0;
    logic bad = 1'b0;
    logic [40:0] noise = '0;
    logic [63:0] preds = '0;
    uec_inst_s req = '0;
    uec_inst_s in_inst;
    uec_result_s out_res;
    logic in_valid, gs, ge, out_valid;
    int n_fail = 0;
    int check_count = 0;
    initial forever #5 clk = ~clk;
    uec_fetch_model fm (.clk(clk), .send(send), .req(req), .noise(noise),
        .bad(bad), .in_valid(in_valid), .in_inst(in_inst),
        .group_start(gs), .group_end(ge));
    // Enable is lowered in one scenario to prove the hold
    uec_classifier dut (.clk(clk), .srst(srst), .ce(ce),
        .in_valid(in_valid), .in_inst(in_inst), .group_start(gs),
        .group_end(ge), .predicate_register_file(preds),
        .out_valid(out_valid), .out_res(out_res));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string w, input logic [7:0] s, e);
        check_count++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %s exp %0h seen %0h", w, e, s);
        end
    endtask : chk
    function automatic uec_inst_s mk(uec_class_e c, logic [40:0] w, m,
                                     logic z);
        mk = '0;
        mk.cls = c;
        mk.word = w;
        mk.zero_mask = m;
        mk.zero_has_qp = z;
    endfunction : mk
    task automatic run(input uec_inst_s i, uec_action_e a, logic p);
        @(posedge clk);
        send = 1'b1;
        req = i;
        @(posedge clk);
        send = 1'b0;
        @(negedge clk);
        chk("valid", out_valid, 1'b1);
        chk("class", out_res.cls, i.cls);
        chk("action", out_res.action, a);
        chk("fault", out_res.illegal_op, a == UEC_ACT_FAULT);
        chk("place", out_res.placement_err, p);
        chk("sel", out_res.pred_sel, i.word[5:0]);
    endtask : run
    task automatic print_verdict;
        if (n_fail == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_ignored;
        for (int k = 0; k < 4; k++) begin
            noise = {35'(k) * 35'h1a5a5, 6'h00};
            run(mk(UEC_CLS_IGNORED, '0, '0, 0), UEC_ACT_NOP, 0);
            run(mk(UEC_CLS_VALID, 41'h3, '0, 0), UEC_ACT_EXEC, 0);
        end
        noise = '0;
    endtask : t_ignored
    task automatic t_reserved;
        run(mk(UEC_CLS_RESERVED, 41'h5, '0, 1), UEC_ACT_FAULT, 0);
        run(mk(UEC_CLS_RESERVED, '0, '0, 0), UEC_ACT_FAULT, 0);
    endtask : t_reserved
    task automatic t_rsv_pred;
        int qs[4] = '{0, 1, 37, 63};
        foreach (qs[n])
            run(mk(UEC_CLS_RSV_PRED, 41'(qs[n]), '0, 1),
                (qs[n] == 0 || preds[qs[n]]) ? UEC_ACT_FAULT : UEC_ACT_NOP,
                0);
    endtask : t_rsv_pred
    task automatic t_zero;
        run(mk(UEC_CLS_VALID, 41'h100025, 41'h100000, 1), UEC_ACT_NOP, 0);
        run(mk(UEC_CLS_VALID, 41'h100001, 41'h100000, 1), UEC_ACT_FAULT, 0);
        run(mk(UEC_CLS_VALID, 41'h25, 41'h3f, 0), UEC_ACT_FAULT, 0);
    endtask : t_zero
    task automatic t_place;
        uec_inst_s i;
        for (int k = 0; k < 4; k++) begin
            i = mk(UEC_CLS_VALID, '0, '0, 0);
            bad = (k != 0);
            i.tail_mark = (k < 2);
            i.first_mark = (k == 2);
            i.last_mark = (k == 3);
            run(i, UEC_ACT_EXEC, bad);
        end
        bad = 1'b0;
    endtask : t_place
    task automatic t_freeze;
        run(mk(UEC_CLS_RESERVED, '0, '0, 0), UEC_ACT_FAULT, 0);
        ce = 1'b0;
        @(posedge clk);
        send = 1'b1;
        req = mk(UEC_CLS_IGNORED, '0, '0, 0);
        @(posedge clk);
        send = 1'b0;
        @(negedge clk);
        chk("hold act", out_res.action, UEC_ACT_FAULT);
        chk("hold fault", out_res.illegal_op, 1'b1);
        chk("hold valid", out_valid, 1'b1);
        ce = 1'b1;
        @(negedge clk);
        chk("resume valid", out_valid, 1'b0);
    endtask : t_freeze
    initial begin
        repeat (16) @(negedge clk);
        chk("rst valid", out_valid, 1'b0);
        chk("rst act", out_res.action, UEC_ACT_EXEC);
        srst = 1'b0;
        preds = 64'h8000_0000_0000_0002;
        t_ignored();
        t_reserved();
        t_rsv_pred();
        t_zero();
        t_place();
        t_freeze();
        print_verdict();
    end
    // Whole run is well under a few hundred cycles
    initial begin
        repeat (2000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
endmodule : uec_classifier_tb_top
`default_nettype wire
